// File: verilog/sideband_pkg.sv
package sideband_pkg;

  // ==========================================================================
  // register map (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam logic [11:0] CTRL_OFFSET      = 12'h000;
  localparam logic [11:0] MGMT_BASE_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET    = 12'h008;

  // ==========================================================================
  // control register fields
  // ==========================================================================
  localparam int CTRL_CD_BIT = 0;
  localparam int CTRL_NW_BIT = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;
  localparam logic [31:0] MGMT_BASE_RESET = 32'h0003_0000;

  // ==========================================================================
  // status register fields
  // ==========================================================================
  localparam int ST_MODE_BIT    = 0;
  localparam int ST_PEND_BIT    = 1;
  localparam int ST_STOP_BIT    = 2;
  localparam int ST_WB_BIT      = 3;
  localparam int ST_FLOAT_BIT   = 4;
  localparam int ST_BUSY_BIT    = 5;
  localparam int ST_RESTART_BIT = 6;

  // ==========================================================================
  // synchronised pin vector
  // ==========================================================================
  localparam int PIN_COUNT     = 9;
  localparam int PIN_MGMT_IRQ  = 0;
  localparam int PIN_RESTART   = 1;
  localparam int PIN_STOP_REQ  = 2;
  localparam int PIN_UPGRADE   = 3;
  localparam int PIN_POLICY    = 4;
  localparam int PIN_NB_DONE   = 5;
  localparam int PIN_B_DONE    = 6;
  localparam int PIN_ADDRESS_HOLD     = 7;
  localparam int PIN_BACKOFF   = 8;
  // idle level of each pin, used as synchroniser reset value
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 9'h16D;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_MIN_MS  = 1;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_SYNC_STAGES = 2;

  // ==========================================================================
  // state machines
  // ==========================================================================
  typedef enum logic [2:0] {SC_IDLE, SC_HALT, SC_DRAIN, SC_GRANT, SC_STOPPED} stop_state_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_FIRST, BUS_WAIT} bus_state_t;

endpackage

// File: verilog/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import sideband_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic [PIN_COUNT-1:0] pins_async,
  output logic      [PIN_COUNT-1:0] pins_sync
);

  // ==========================================================================
  // two flip-flops per pin
  // ==========================================================================
  logic [PIN_COUNT-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i = i + 1)
    begin : g_bit
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          meta_q[i]    <= PIN_IDLE[i];
          pins_sync[i] <= PIN_IDLE[i];
        end
        else
        begin
          meta_q[i]    <= pins_async[i];
          pins_sync[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: verilog/system_control.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module system_control
  import sideband_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        mgmt_irq_n,
  input  wire logic        warm_restart,
  input  wire logic        clock_stop_req_n,
  input  wire logic        upgrade_present_n,
  input  wire logic        line_policy_sel,
  input  wire logic        nonburst_done_n,
  input  wire logic        burst_done_n,
  input  wire logic        address_hold,
  input  wire logic        backoff_n,
  output logic             mgmt_active_n,
  output logic             write_not_read,
  output logic             outputs_float,
  // core side
  input  wire logic        instr_boundary,
  input  wire logic        higher_irq,
  input  wire logic        pipes_empty,
  input  wire logic        mode_resume_instr,
  input  wire logic        cycle_start,
  input  wire logic        cycle_write,
  input  wire logic        cycle_fill,
  input  wire logic        burst_last,
  output logic             core_run,
  output logic             save_regs,
  output logic             restart_seq,
  output logic             stop_grant_req,
  output logic             cycle_done,
  output logic             fill_done,
  output logic             fill_writeback,
  output logic             writeback_mode,
  output logic             cache_disable_bit,
  output logic             no_writethrough_bit,
  output logic      [31:0] mgmt_area_base
);

  // ==========================================================================
  // pin synchronisers and reset release
  // ==========================================================================
  logic [PIN_COUNT-1:0]       pins;
  logic [RST_SYNC_STAGES-1:0] rst_pipe_q;
  logic                       in_reset;

  // synchronisers run through reset so the straps are seen before it falls
  pin_sync u_sync (
    .mclk       (mclk),
    .rst        (1'b0),
    .pins_async ({backoff_n, address_hold, burst_done_n, nonburst_done_n,
                  line_policy_sel, upgrade_present_n, clock_stop_req_n,
                  warm_restart, mgmt_irq_n}),
    .pins_sync  (pins)
  );

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rst_pipe_q <= '1;
    else
      rst_pipe_q <= {rst_pipe_q[RST_SYNC_STAGES-2:0], 1'b0};
  end

  assign in_reset = rst_pipe_q[RST_SYNC_STAGES-1];

  // ==========================================================================
  // straps, caught while reset is still seen internally
  // ==========================================================================
  logic upgrade_strap_q;
  logic float_q;
  logic float_d;

  assign float_d = upgrade_strap_q & ~pins[PIN_UPGRADE] & ~in_reset;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      upgrade_strap_q  <= 1'b0;
      writeback_mode   <= 1'b0;
    end
    else if (in_reset)
    begin
      upgrade_strap_q  <= ~pins[PIN_UPGRADE];
      writeback_mode   <= pins[PIN_POLICY];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      float_q <= 1'b0;
    else
      float_q <= float_d;
  end

  assign outputs_float = float_q;

  // ==========================================================================
  // management interrupt
  // ==========================================================================
  logic irq_prev_q;
  logic irq_pend_q;
  logic irq_fall;
  logic take_irq;
  logic mgmt_mode_q;
  logic boundary;

  assign boundary = instr_boundary & core_run;
  assign irq_fall = irq_prev_q & ~pins[PIN_MGMT_IRQ];
  assign take_irq = boundary & irq_pend_q & ~mgmt_mode_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      irq_prev_q <= 1'b1;
    else
      irq_prev_q <= pins[PIN_MGMT_IRQ];
  end

  // an edge in the service cycle stays pending
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      irq_pend_q <= 1'b0;
    else if (irq_fall & (~irq_pend_q | take_irq))
      irq_pend_q <= 1'b1;
    else if (take_irq)
      irq_pend_q <= 1'b0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mgmt_mode_q   <= 1'b0;
      mgmt_active_n <= 1'b1;
    end
    else if (take_irq)
    begin
      mgmt_mode_q   <= 1'b1;
      mgmt_active_n <= 1'b0;
    end
    else if (mgmt_mode_q & mode_resume_instr)
    begin
      mgmt_mode_q   <= 1'b0;
      mgmt_active_n <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      save_regs <= 1'b0;
    else
      save_regs <= take_irq;
  end

  // ==========================================================================
  // warm restart
  // ==========================================================================
  logic restart_pend_q;
  logic take_restart;

  assign take_restart = boundary & restart_pend_q & ~take_irq;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      restart_pend_q <= 1'b0;
    else if (pins[PIN_RESTART])
      restart_pend_q <= 1'b1;
    else if (take_restart)
      restart_pend_q <= 1'b0;
  end

  // straps, cache bits and base are never touched by this pulse
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      restart_seq <= 1'b0;
    else
      restart_seq <= take_restart;
  end

  // ==========================================================================
  // stop clock sequence
  // ==========================================================================
  stop_state_t stop_q;
  logic        bus_end;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      stop_q <= SC_IDLE;
    else
    begin
      case (stop_q)
        SC_IDLE:
          if (~pins[PIN_STOP_REQ])
            stop_q <= SC_HALT;
        SC_HALT:
          if (boundary & ~irq_pend_q & ~higher_irq & ~restart_pend_q)
            stop_q <= SC_DRAIN;
        SC_DRAIN:
          if (pipes_empty)
            stop_q <= SC_GRANT;
        SC_GRANT:
          if (bus_end)
            stop_q <= SC_STOPPED;
        SC_STOPPED:
          if (pins[PIN_STOP_REQ])
            stop_q <= SC_IDLE;
        default:
          stop_q <= SC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      stop_grant_req <= 1'b0;
    else
      stop_grant_req <= (stop_q == SC_GRANT) & ~bus_end;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      core_run <= 1'b0;
    else
      core_run <= ~in_reset & ~float_d & (stop_q == SC_IDLE || stop_q == SC_HALT);
  end

  // ==========================================================================
  // bus cycle completion
  // ==========================================================================
  bus_state_t bus_q;
  logic       first_xfer_q;
  logic       fill_q;
  logic       nb_ready;
  logic       b_ready;

  // address hold does not gate the readies
  assign nb_ready = ~pins[PIN_NB_DONE];
  assign b_ready  = ~pins[PIN_B_DONE];
  assign bus_end  = (bus_q == BUS_WAIT) & (nb_ready | (b_ready & burst_last));

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      bus_q <= BUS_IDLE;
    else
    begin
      case (bus_q)
        BUS_IDLE:
          if (cycle_start)
            bus_q <= BUS_FIRST;
        BUS_FIRST:
          bus_q <= pins[PIN_BACKOFF] ? BUS_WAIT : BUS_IDLE;
        BUS_WAIT:
          if (~pins[PIN_BACKOFF] | bus_end)
            bus_q <= BUS_IDLE;
        default:
          bus_q <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      write_not_read <= 1'b0;
      fill_q         <= 1'b0;
    end
    else if (bus_q == BUS_IDLE && cycle_start)
    begin
      write_not_read <= cycle_write;
      fill_q         <= cycle_fill & ~cycle_write;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      first_xfer_q <= 1'b0;
    else if (bus_q == BUS_FIRST)
      first_xfer_q <= 1'b1;
    else if (bus_q == BUS_WAIT && (nb_ready | b_ready))
      first_xfer_q <= 1'b0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      fill_writeback <= 1'b0;
    else if (bus_q == BUS_WAIT && first_xfer_q && fill_q && (nb_ready | b_ready))
      fill_writeback <= writeback_mode & pins[PIN_POLICY] & ~no_writethrough_bit;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cycle_done <= 1'b0;
      fill_done  <= 1'b0;
    end
    else
    begin
      cycle_done <= bus_end;
      fill_done  <= bus_end & fill_q;
    end
  end

  // ==========================================================================
  // apb register file
  // ==========================================================================
  logic        setup;
  logic        access;
  logic [31:0] rd_d;
  logic        err_d;
  logic [31:0] status;

  assign setup  = psel & ~penable;
  assign access = psel & penable & pready;

  assign status = {25'h000_0000, restart_pend_q, (bus_q != BUS_IDLE), float_q,
                   writeback_mode, (stop_q == SC_STOPPED), irq_pend_q, mgmt_mode_q};

  always_comb
  begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == CTRL_OFFSET)
      rd_d = {30'h0000_0000, no_writethrough_bit, cache_disable_bit};
    else if (paddr == MGMT_BASE_OFFSET)
      rd_d = mgmt_area_base;
    else if (paddr == STATUS_OFFSET)
      rd_d = status;
    else
      err_d = 1'b1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & err_d;
      prdata  <= (setup & ~pwrite) ? rd_d : 32'h0000_0000;
    end
  end

  // hard reset only; warm restart leaves these alone
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cache_disable_bit   <= CTRL_RESET[CTRL_CD_BIT];
      no_writethrough_bit <= CTRL_RESET[CTRL_NW_BIT];
    end
    else if (access && pwrite && paddr == CTRL_OFFSET)
    begin
      cache_disable_bit   <= pwdata[CTRL_CD_BIT];
      no_writethrough_bit <= pwdata[CTRL_NW_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      mgmt_area_base <= MGMT_BASE_RESET;
    else if (access && pwrite && paddr == MGMT_BASE_OFFSET)
      mgmt_area_base <= pwdata;
  end

endmodule
`default_nettype wire

// File: verif/sideband_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sideband_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        instr_boundary,
  input wire logic        pipes_empty,
  input wire logic        mode_resume_instr,
  input wire logic        cycle_start,
  input wire logic        cycle_write,
  input wire logic        core_run,
  input wire logic        save_regs,
  input wire logic        restart_seq,
  input wire logic        stop_grant_req,
  input wire logic        cycle_done,
  input wire logic        write_not_read,
  input wire logic        writeback_mode,
  input wire logic        fill_writeback,
  input wire logic        outputs_float,
  input wire logic        mgmt_active_n,
  input wire logic        cache_disable_bit,
  input wire logic [31:0] mgmt_area_base
);
  // ==========================================================================
  // properties
  // ==========================================================================
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_entry;
    save_regs && $fell(mgmt_active_n);
  endsequence
  sequence s_no_done2;
    !cycle_done ##1 !cycle_done;
  endsequence
  sequence s_drained;
    $past(pipes_empty) || $past(pipes_empty, 2);
  endsequence

  property p_core_hold;
    disable iff (1'b0) rst |-> !core_run;
  endproperty
  property p_entry;
    save_regs |-> s_entry;
  endproperty
  property p_boundary;
    save_regs |-> $past(instr_boundary) && $past(core_run);
  endproperty
  property p_active;
    $changed(mgmt_active_n) |-> save_regs || $past(mode_resume_instr);
  endproperty
  property p_restart;
    restart_seq |-> $past(instr_boundary);
  endproperty
  property p_keep;
    restart_seq && !$past(psel) |->
      $stable(cache_disable_bit) && $stable(mgmt_area_base) && $stable(writeback_mode);
  endproperty
  property p_grant;
    $rose(stop_grant_req) |-> s_drained;
  endproperty
  property p_first;
    cycle_start |=> s_no_done2;
  endproperty
  property p_wnr;
    $changed(write_not_read) |-> $past(cycle_start) && write_not_read == $past(cycle_write);
  endproperty
  property p_wt;
    !writeback_mode |-> !fill_writeback;
  endproperty
  property p_float;
    outputs_float |-> !core_run;
  endproperty

  a_core_hold: assert property (p_core_hold) else $error("core runs in reset");
  a_entry: assert property (p_entry) else $error("save without entry");
  a_boundary: assert property (p_boundary) else $error("entry off boundary");
  a_active: assert property (p_active) else $error("active output moved");
  a_restart: assert property (p_restart) else $error("restart off boundary");
  a_keep: assert property (p_keep) else $error("restart changed state");
  a_grant: assert property (p_grant) else $error("grant before drain");
  a_first: assert property (p_first) else $error("early cycle end");
  a_wnr: assert property (p_wnr) else $error("direction wrong");
  a_wt: assert property (p_wt) else $error("write-back line in wt mode");
  a_float: assert property (p_float) else $error("float while running");
endmodule
`default_nettype wire

// File: verif/chipset_model.sv
`timescale 1ns/10ps
`default_nettype none
module chipset_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       cycle_start,
  input  wire logic       stop_grant_req,
  input  wire logic       stray,
  input  wire logic [1:0] dly,
  output logic            nonburst_done_n
);
  logic [2:0] cnt_q;
  logic       gnt_q;

  // ready after a chosen wait, for bus cycles and the stop-grant cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q           <= 3'h0;
      gnt_q           <= 1'b0;
      nonburst_done_n <= 1'b1;
    end
    else
    begin
      gnt_q <= stop_grant_req;
      if (cycle_start || (stop_grant_req && !gnt_q))
        cnt_q <= {1'b0, dly} + 3'h1;
      else if (cnt_q != 3'h0)
        cnt_q <= cnt_q - 3'h1;
      nonburst_done_n <= !(stray || cnt_q == 3'h1);
    end
  end
endmodule
`default_nettype wire

// File: verif/test_system_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_system_control
  import sideband_pkg::*;
;
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, mgmt_area_base, base;
  logic        pready, pslverr, mgmt_active_n, write_not_read, outputs_float, nonburst_done_n;
  logic        mgmt_irq_n = 1'b1, warm_restart = 1'b0, clock_stop_req_n = 1'b1;
  logic        upgrade_present_n = 1'b1, line_policy_sel = 1'b1, address_hold = 1'b0;
  logic        instr_boundary = 1'b0, pipes_empty = 1'b1, mode_resume_instr = 1'b0;
  logic        cycle_start = 1'b0, cycle_write = 1'b0, cycle_fill = 1'b0, stray = 1'b0;
  logic        core_run, save_regs, restart_seq, stop_grant_req, cycle_done, fill_done;
  logic        fill_writeback, writeback_mode, cache_disable_bit, no_writethrough_bit;
  logic        in_stop = 1'b0, fwb, pol;
  logic [1:0]  dly = 2'h0;
  logic [4:0]  watch;
  logic [32:0] exp_bus[$];
  logic [2:0]  exp_cyc[$];
  integer      seed = 39475, n_mismatch = 0, checks_done = 0, n_save = 0, n_rst = 0, k, p;

  system_control uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mgmt_irq_n, .warm_restart, .clock_stop_req_n, .upgrade_present_n,
    .line_policy_sel, .nonburst_done_n, .burst_done_n(1'b1), .address_hold,
    .backoff_n(1'b1), .mgmt_active_n, .write_not_read, .outputs_float, .instr_boundary,
    .higher_irq(1'b0), .pipes_empty, .mode_resume_instr, .cycle_start, .cycle_write,
    .cycle_fill, .burst_last(1'b0), .core_run, .save_regs, .restart_seq, .stop_grant_req,
    .cycle_done, .fill_done, .fill_writeback, .writeback_mode, .cache_disable_bit,
    .no_writethrough_bit, .mgmt_area_base);
  chipset_model far_end (.mclk, .rst, .cycle_start, .stop_grant_req, .stray, .dly,
    .nonburst_done_n);

  always #12.5 mclk = ~mclk;
  assign watch = {stop_grant_req, save_regs, cycle_done, core_run, pready};

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] ex);
    checks_done++;
    if (seen !== ex)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // 0 pready, 1 core_run, 2 cycle_done, 3 save_regs, 4 stop_grant_req
  task automatic wait_sig(input int w, input logic v);
    int j;
    for (j = 0; j < 300; j++)
    begin
      @(posedge mclk);
      if (watch[w] === v)
        return;
    end
    chk("wait", 1'b0, 1'b1);
    complete_run;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] ex);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    exp_bus.push_back(ex);
    @(posedge mclk);
    penable <= 1'b1;
    wait_sig(0, 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic bnd;
    @(posedge mclk) instr_boundary <= 1'b1;
    @(posedge mclk) instr_boundary <= 1'b0;
  endtask

  // ==========================================================================
  // result monitor
  // ==========================================================================
  always @(posedge mclk)
  begin
    if (psel && penable && pready === 1'b1)
      chk("apb", {pslverr, pwrite ? 32'h0000_0000 : prdata}, exp_bus.pop_front());
    if (cycle_done === 1'b1 && !in_stop)
      chk("cycle", {write_not_read, fill_done, fill_writeback}, exp_cyc.pop_front());
    if (save_regs === 1'b1)
      n_save++;
    if (restart_seq === 1'b1)
      n_rst++;
  end

  initial
  begin
    tick(5);
    rst <= 1'b0;
    wait_sig(1, 1'b1);
    chk("writeback_mode", writeback_mode, 1'b1);
    apb(1'b0, MGMT_BASE_OFFSET, 32'h0000_0000, {1'b0, MGMT_BASE_RESET});
    base = $random(seed);
    apb(1'b1, MGMT_BASE_OFFSET, base, 33'h0_0000_0000);
    apb(1'b0, MGMT_BASE_OFFSET, 32'h0000_0000, {1'b0, base});
    apb(1'b0, CTRL_OFFSET, 32'h0000_0000, 33'h0_0000_0000);
    apb(1'b1, STATUS_OFFSET, 32'hFFFF_FFFF, 33'h0_0000_0000);
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000, 33'h0_0000_0008);
    apb(1'b1, 12'h00C, base, 33'h1_0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000, 33'h1_0000_0000);
    chk("mgmt_area_base", mgmt_area_base, base);
    $display("test registers done");
    fwb = 1'b0;
    for (p = 0; p < 2; p++)
    begin
      apb(1'b1, CTRL_OFFSET, p ? 32'h0000_0002 : 32'h0000_0000, 33'h0_0000_0000);
      tick(1);
      chk("no_writethrough_bit", no_writethrough_bit, p[0]);
      for (k = 0; k < 5; k++)
      begin
        pol = $random(seed);
        @(posedge mclk) stray <= 1'b1;
        line_policy_sel <= pol;
        address_hold <= k[0];
        dly <= $random(seed);
        @(posedge mclk) stray <= 1'b0;
        if (k < 4)
        begin
          @(posedge mclk) cycle_start <= 1'b1;
          cycle_write <= k[0];
          cycle_fill <= k[1];
          if (k[1] && !k[0])
            fwb = pol && !p;
          exp_cyc.push_back({k[0], k[1] & ~k[0], fwb});
          @(posedge mclk) cycle_start <= 1'b0;
          wait_sig(2, 1'b1);
        end
        else
          tick(10);
      end
    end
    $display("test bus cycles done");
    @(posedge mclk) mgmt_irq_n <= 1'b0;
    tick(3);
    mgmt_irq_n <= 1'b1;
    tick(3);
    mgmt_irq_n <= 1'b0;
    tick(4);
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000, 33'h0_0000_000A);
    bnd;
    wait_sig(3, 1'b1);
    chk("mgmt_active_n", mgmt_active_n, 1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000, 33'h0_0000_0009);
    bnd;
    tick(4);
    chk("mgmt_active_n", mgmt_active_n, 1'b0);
    @(posedge mclk) mode_resume_instr <= 1'b1;
    @(posedge mclk) mode_resume_instr <= 1'b0;
    tick(3);
    chk("mgmt_active_n", mgmt_active_n, 1'b1);
    bnd;
    tick(5);
    chk("entries", n_save, 1);
    mgmt_irq_n <= 1'b1;
    $display("test management done");
    @(posedge mclk) warm_restart <= 1'b1;
    tick(2);
    warm_restart <= 1'b0;
    tick(4);
    chk("restarts", n_rst, 0);
    bnd;
    tick(3);
    chk("restarts", n_rst, 1);
    apb(1'b0, CTRL_OFFSET, 32'h0000_0000, 33'h0_0000_0002);
    chk("mgmt_area_base", mgmt_area_base, base);
    chk("writeback_mode", writeback_mode, 1'b1);
    $display("test restart done");
    wait_sig(1, 1'b1);
    in_stop = 1'b1;
    @(posedge mclk) pipes_empty <= 1'b0;
    clock_stop_req_n <= 1'b0;
    tick(4);
    bnd;
    tick(6);
    chk("stop_grant_req", stop_grant_req, 1'b0);
    pipes_empty <= 1'b1;
    wait_sig(4, 1'b1);
    // core runs the stop-grant bus cycle asked for
    @(posedge mclk) cycle_start <= 1'b1;
    @(posedge mclk) cycle_start <= 1'b0;
    wait_sig(4, 1'b0);
    wait_sig(1, 1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000, 33'h0_0000_000C);
    clock_stop_req_n <= 1'b1;
    wait_sig(1, 1'b1);
    in_stop = 1'b0;
    $display("test stop clock done");
    @(posedge mclk) rst <= 1'b1;
    upgrade_present_n <= 1'b0;
    line_policy_sel <= 1'b0;
    tick(5);
    rst <= 1'b0;
    tick(8);
    chk("outputs_float", outputs_float, 1'b1);
    chk("core_run", core_run, 1'b0);
    chk("writeback_mode", writeback_mode, 1'b0);
    chk("queues", exp_bus.size() + exp_cyc.size(), 0);
    $display("test straps done");
    complete_run;
  end
endmodule

bind system_control sideband_asserts chk_i (.mclk, .rst, .psel, .instr_boundary, .pipes_empty,
  .mode_resume_instr, .cycle_start, .cycle_write, .core_run, .save_regs, .restart_seq,
  .stop_grant_req, .cycle_done, .write_not_read, .writeback_mode, .fill_writeback,
  .outputs_float, .mgmt_active_n, .cache_disable_bit, .mgmt_area_base);
`default_nettype wire
